// >>> rtl/epd_serial_pkg.sv
/*
 * Shared constants of the host serial port and the temperature-sensor master:
 * frame lengths, reset values, port states and sensor bus timing.
 * Assumes a 100 MHz system clock that is much faster than the host serial clock.
 */
package epd_serial_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // Last bit index of a frame: 8-bit frames in 4-wire, 9-bit in 3-wire
    localparam logic [3:0] LAST_BIT_4WIRE = 4'h7;
    localparam logic [3:0] LAST_BIT_3WIRE = 4'h8;
    localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] SYNC_RESET = 3'h7;

    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_SHIFT = 2'b01,
        PS_READ = 2'b11
    } portState_t;

    // Sensor bus: one bit takes four quarter phases
    localparam int SENSOR_BIT_NS = 10000;
    localparam int SENSOR_QUARTER_CYCLES = SENSOR_BIT_NS / 4 / CLK_PERIOD_NS;
    localparam logic [8:0] QUARTER_LAST = 9'(SENSOR_QUARTER_CYCLES - 1);
    localparam logic [3:0] SENSOR_ACK_BIT = 4'h8;
    localparam logic [1:0] SENSOR_LAST_BYTE = 2'h2;
    localparam logic [6:0] SENSOR_ADDR_DEFAULT = 7'h48;

    typedef enum logic [2:0] {
        SN_IDLE = 3'b000,
        SN_START = 3'b001,
        SN_BITS = 3'b011,
        SN_STOP = 3'b010
    } sensorState_t;

endpackage : epd_serial_pkg

// >>> rtl/sensor_i2c_master.sv
/*
 * Bus master that reads two bytes from the external temperature sensor.
 * Assumes an external pull-up on the sensor data line and a sensor that answers
 * a read of its address with a high byte then a low byte.
 */
module sensor_i2c_master #(
    parameter logic [6:0] SENSOR_ADDR = epd_serial_pkg::SENSOR_ADDR_DEFAULT
) (
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Request and result
    input wire logic start,
    output logic active,
    output logic [15:0] reading,
    // Sensor pins
    output logic sensorI2cClock,
    input wire logic sensorI2cDataIn,
    output logic sensorI2cDataOut,
    output logic sensorI2cDataOe_n
);

    typedef struct packed {
        epd_serial_pkg::sensorState_t st;
        logic [8:0] div;
        logic [1:0] quarter;
        logic [3:0] bitIdx;
        logic [1:0] byteIdx;
        logic [2:0] sdaSync;
        logic sdaLvl;
        logic [15:0] shiftIn;
        logic [15:0] result;
        logic sclOut;
        logic releaseSda;
    } sensorRegs_t;

    sensorRegs_t s_reg;
    sensorRegs_t s_next;
    logic tick;
    logic [7:0] addrByte;
    logic txBit;

    assign addrByte = {SENSOR_ADDR, 1'b1};
    assign tick = (s_reg.div == epd_serial_pkg::QUARTER_LAST);

    always_comb
    begin
        s_next = s_reg;
        s_next.sdaSync = {s_reg.sdaSync[1:0], sensorI2cDataIn};
        if (s_reg.sdaSync[1] == s_reg.sdaSync[2])
        begin
            s_next.sdaLvl = s_reg.sdaSync[2];
        end
        s_next.div = tick ? 9'h000 : s_reg.div + 9'h001;
        // Address bits, then released reads; master acks the first read only
        if (s_reg.byteIdx == 2'h0)
        begin
            txBit = (s_reg.bitIdx == epd_serial_pkg::SENSOR_ACK_BIT) ? 1'b1
                : addrByte[3'(7 - s_reg.bitIdx)];
        end
        else if (s_reg.bitIdx == epd_serial_pkg::SENSOR_ACK_BIT)
        begin
            txBit = (s_reg.byteIdx == epd_serial_pkg::SENSOR_LAST_BYTE);
        end
        else
        begin
            txBit = 1'b1;
        end
        case (s_reg.st)
            epd_serial_pkg::SN_IDLE:
            begin
                s_next.sclOut = 1'b1;
                s_next.releaseSda = 1'b1;
                s_next.quarter = 2'h0;
                if (start)
                begin
                    s_next.st = epd_serial_pkg::SN_START;
                    s_next.div = 9'h000;
                end
            end
            epd_serial_pkg::SN_START:
            begin
                if (tick)
                begin
                    s_next.quarter = s_reg.quarter + 2'h1;
                    if (s_reg.quarter == 2'h1)
                    begin
                        s_next.releaseSda = 1'b0;
                    end
                    if (s_reg.quarter == 2'h3)
                    begin
                        s_next.sclOut = 1'b0;
                        s_next.st = epd_serial_pkg::SN_BITS;
                        s_next.bitIdx = 4'h0;
                        s_next.byteIdx = 2'h0;
                    end
                end
            end
            epd_serial_pkg::SN_BITS:
            begin
                if (tick)
                begin
                    s_next.quarter = s_reg.quarter + 2'h1;
                    case (s_reg.quarter)
                        2'h0: s_next.releaseSda = txBit;
                        2'h1: s_next.sclOut = 1'b1;
                        2'h2:
                        begin
                            if (s_reg.byteIdx != 2'h0 &&
                                s_reg.bitIdx != epd_serial_pkg::SENSOR_ACK_BIT)
                            begin
                                s_next.shiftIn = {s_reg.shiftIn[14:0], s_reg.sdaLvl};
                            end
                        end
                        default:
                        begin
                            s_next.sclOut = 1'b0;
                            s_next.bitIdx = s_reg.bitIdx + 4'h1;
                            if (s_reg.bitIdx == epd_serial_pkg::SENSOR_ACK_BIT)
                            begin
                                s_next.bitIdx = 4'h0;
                                s_next.byteIdx = s_reg.byteIdx + 2'h1;
                                if (s_reg.byteIdx == epd_serial_pkg::SENSOR_LAST_BYTE)
                                begin
                                    s_next.st = epd_serial_pkg::SN_STOP;
                                end
                            end
                        end
                    endcase
                end
            end
            epd_serial_pkg::SN_STOP:
            begin
                if (tick)
                begin
                    s_next.quarter = s_reg.quarter + 2'h1;
                    case (s_reg.quarter)
                        2'h0: s_next.releaseSda = 1'b0;
                        2'h1: s_next.sclOut = 1'b1;
                        2'h2: s_next.releaseSda = 1'b1;
                        default:
                        begin
                            s_next.st = epd_serial_pkg::SN_IDLE;
                            s_next.result = s_reg.shiftIn;
                        end
                    endcase
                end
            end
            default: s_next.st = epd_serial_pkg::SN_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '{st: epd_serial_pkg::SN_IDLE, sdaSync: epd_serial_pkg::SYNC_RESET,
                sdaLvl: 1'b1, sclOut: 1'b1, releaseSda: 1'b1, default: '0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Data line open drain: only ever pulls low, never drives high; clock driven both ways
    assign active = (s_reg.st != epd_serial_pkg::SN_IDLE);
    assign reading = s_reg.result;
    assign sensorI2cClock = s_reg.sclOut;
    assign sensorI2cDataOut = 1'b0;
    assign sensorI2cDataOe_n = s_reg.releaseSda;

    sensor_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_reg.st == epd_serial_pkg::SN_IDLE) |-> (sensorI2cClock && sensorI2cDataOe_n))
        else $error("sensor lines not released while idle");

endmodule : sensor_i2c_master

// >>> rtl/epd_host_serial_port.sv
/*
 * Host serial port of the display controller: receives command and data bytes
 * in 4-wire or 3-wire form, returns read bytes, and drives the busy pin.
 * Assumes every pin is asynchronous to clk and the serial clock is at most
 * 20 MHz, so each serial clock level lasts at least two system clocks.
 */
// Notes on behaviour
// - Serial traffic is taken only while chip select is low.
// - In 4-wire mode data/command pin high means data, low means command.
// - Reset pin is active low and clears the port.
// - Busy is high during waveform output and sensor communication.
// - Strap low selects 4-wire 8-bit frames, high selects 3-wire 9-bit.
// - 4-wire bits shift in on rising serial clock, bit 7 first.
// - A complete byte goes to the data or command path by its qualifier.
// - 3-wire frame: qualifier bit first, then bits 7 down to 0.
// - 3-wire qualifier 0 means command, 1 means data.
// - Device returns read data on the data line; reads at most 2.5 MHz.
// - Device masters the sensor bus: drives its clock, shares its data line.
module epd_host_serial_port (
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Host pins
    input wire logic reset_low_input_n,
    input wire logic interfaceWidthStrap,
    input wire logic chipSelect_n,
    input wire logic serialClock,
    input wire logic dataCommandSel,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe_n,
    output logic busy,
    // Received bytes
    output logic [7:0] byteData,
    output logic commandValid,
    output logic dataValid,
    // Read return
    input wire logic readLoad,
    input wire logic [7:0] readData,
    // Busy sources
    input wire logic waveformActive,
    input wire logic sensorStart,
    output logic [15:0] sensorReading,
    // Sensor pins
    output logic sensorI2cClock,
    input wire logic sensorI2cDataIn,
    output logic sensorI2cDataOut,
    output logic sensorI2cDataOe_n
);

    typedef struct packed {
        logic [2:0] csSync;
        logic [2:0] sckSync;
        logic [2:0] sdiSync;
        logic [2:0] dcSync;
        logic [2:0] rstSync;
        logic [2:0] strapSync;
        logic csLvl;
        logic sckLvl;
        logic sdiLvl;
        logic dcLvl;
        logic rstLvl;
        logic strapLvl;
        epd_serial_pkg::portState_t mode;
        logic [3:0] bitCnt;
        logic [7:0] shiftReg;
        logic [7:0] byteOut;
        logic cmdStrobe;
        logic dataStrobe;
        logic [7:0] readShift;
        logic busyOut;
    } portRegs_t;

    portRegs_t p_reg;
    portRegs_t p_next;
    logic sensorActive;
    logic sckRise;
    logic sckFall;
    logic csRise;
    logic lastBit;
    logic qualifier;

    // Counts a change only once the second and third stages agree
    function automatic logic filtered(input logic [2:0] sync, input logic prev);
        filtered = (sync[1] == sync[2]) ? sync[2] : prev;
    endfunction : filtered

    always_comb
    begin
        p_next = p_reg;
        p_next.csSync = {p_reg.csSync[1:0], chipSelect_n};
        p_next.sckSync = {p_reg.sckSync[1:0], serialClock};
        p_next.sdiSync = {p_reg.sdiSync[1:0], serialDataIn};
        p_next.dcSync = {p_reg.dcSync[1:0], dataCommandSel};
        p_next.rstSync = {p_reg.rstSync[1:0], reset_low_input_n};
        p_next.strapSync = {p_reg.strapSync[1:0], interfaceWidthStrap};
        p_next.csLvl = filtered(p_reg.csSync, p_reg.csLvl);
        p_next.sckLvl = filtered(p_reg.sckSync, p_reg.sckLvl);
        p_next.sdiLvl = filtered(p_reg.sdiSync, p_reg.sdiLvl);
        p_next.dcLvl = filtered(p_reg.dcSync, p_reg.dcLvl);
        p_next.rstLvl = filtered(p_reg.rstSync, p_reg.rstLvl);
        p_next.strapLvl = filtered(p_reg.strapSync, p_reg.strapLvl);
        sckRise = !p_reg.sckLvl && p_next.sckLvl;
        sckFall = p_reg.sckLvl && !p_next.sckLvl;
        csRise = !p_reg.csLvl && p_next.csLvl;
        lastBit = (p_reg.bitCnt == (p_reg.strapLvl ? epd_serial_pkg::LAST_BIT_3WIRE
            : epd_serial_pkg::LAST_BIT_4WIRE));
        // In 3-wire form the first bit has reached bit 7 by the last edge
        qualifier = p_reg.strapLvl ? p_reg.shiftReg[7] : p_reg.dcLvl;
        p_next.cmdStrobe = 1'b0;
        p_next.dataStrobe = 1'b0;
        p_next.busyOut = waveformActive || sensorActive;
        case (p_reg.mode)
            epd_serial_pkg::PS_IDLE:
            begin
                p_next.bitCnt = epd_serial_pkg::BIT_COUNT_RESET;
                if (!p_reg.csLvl)
                begin
                    p_next.mode = epd_serial_pkg::PS_SHIFT;
                end
            end
            epd_serial_pkg::PS_SHIFT:
            begin
                if (csRise || p_reg.csLvl)
                begin
                    p_next.mode = epd_serial_pkg::PS_IDLE;
                    p_next.bitCnt = epd_serial_pkg::BIT_COUNT_RESET;
                end
                else if (sckRise)
                begin
                    p_next.shiftReg = {p_reg.shiftReg[6:0], p_reg.sdiLvl};
                    p_next.bitCnt = p_reg.bitCnt + 4'h1;
                    if (lastBit)
                    begin
                        p_next.bitCnt = epd_serial_pkg::BIT_COUNT_RESET;
                        p_next.byteOut = {p_reg.shiftReg[6:0], p_reg.sdiLvl};
                        p_next.dataStrobe = qualifier;
                        p_next.cmdStrobe = !qualifier;
                    end
                end
            end
            epd_serial_pkg::PS_READ:
            begin
                // Next bit is presented on the falling edge for the host's rising edge
                // Often loaded while select is still high, so only a rising select or the reset pin ends it
                if (csRise)
                begin
                    p_next.mode = epd_serial_pkg::PS_IDLE;
                end
                else if (sckFall)
                begin
                    p_next.readShift = {p_reg.readShift[6:0], 1'b0};
                end
            end
            default: p_next.mode = epd_serial_pkg::PS_IDLE;
        endcase
        if (readLoad && p_reg.mode != epd_serial_pkg::PS_READ)
        begin
            p_next.readShift = readData;
            p_next.mode = epd_serial_pkg::PS_READ;
            p_next.bitCnt = epd_serial_pkg::BIT_COUNT_RESET;
        end
        if (!p_reg.rstLvl)
        begin
            p_next.mode = epd_serial_pkg::PS_IDLE;
            p_next.bitCnt = epd_serial_pkg::BIT_COUNT_RESET;
            p_next.shiftReg = epd_serial_pkg::BYTE_RESET;
            p_next.cmdStrobe = 1'b0;
            p_next.dataStrobe = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            p_reg <= '{csSync: epd_serial_pkg::SYNC_RESET, rstSync: epd_serial_pkg::SYNC_RESET,
                csLvl: 1'b1, rstLvl: 1'b1, mode: epd_serial_pkg::PS_IDLE, default: '0};
        end
        else
        begin
            p_reg <= p_next;
        end
    end

    sensor_i2c_master sensor (
        .clk(clk),
        .rst_n(rst_n),
        .start(sensorStart && p_reg.rstLvl),
        .active(sensorActive),
        .reading(sensorReading),
        .sensorI2cClock(sensorI2cClock),
        .sensorI2cDataIn(sensorI2cDataIn),
        .sensorI2cDataOut(sensorI2cDataOut),
        .sensorI2cDataOe_n(sensorI2cDataOe_n)
    );

    assign byteData = p_reg.byteOut;
    assign commandValid = p_reg.cmdStrobe;
    assign dataValid = p_reg.dataStrobe;
    assign busy = p_reg.busyOut;
    assign serialDataOut = p_reg.readShift[7];
    assign serialDataOe_n = !(p_reg.mode == epd_serial_pkg::PS_READ && !p_reg.csLvl);

    cs_gates_bytes_a: assert property (@(posedge clk) disable iff (!rst_n)
        (commandValid || dataValid) |-> $past(!p_reg.csLvl))
        else $error("byte accepted with chip select high");

    four_wire_route_a: assert property (@(posedge clk) disable iff (!rst_n)
        (commandValid || dataValid) && $past(!p_reg.strapLvl)
        |-> dataValid == $past(p_reg.dcLvl))
        else $error("4-wire byte routed against data/command pin");

    pin_reset_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
        !p_reg.rstLvl |=> p_reg.bitCnt == 4'h0 && !commandValid && !dataValid)
        else $error("reset pin did not clear the port");

    busy_tracks_a: assert property (@(posedge clk) disable iff (!rst_n)
        (waveformActive || sensorActive) |=> busy)
        else $error("busy low during waveform or sensor activity");

    frame_length_a: assert property (@(posedge clk) disable iff (!rst_n)
        (commandValid || dataValid)
        |-> $past(p_reg.bitCnt) == ($past(p_reg.strapLvl) ? 4'h8 : 4'h7))
        else $error("frame length does not match strap");

    msb_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        (commandValid || dataValid)
        |-> byteData == {$past(p_reg.shiftReg[6:0]), $past(p_reg.sdiLvl)})
        else $error("received byte not assembled msb first");

    one_route_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(commandValid && dataValid))
        else $error("byte sent to both command and data paths");

    three_wire_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (commandValid || dataValid) && $past(p_reg.strapLvl)
        |-> dataValid == $past(p_reg.shiftReg[7]))
        else $error("3-wire qualifier misrouted");

    partial_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (p_reg.mode == epd_serial_pkg::PS_SHIFT) && p_reg.csLvl
        |=> p_reg.bitCnt == 4'h0 && !commandValid && !dataValid)
        else $error("partial frame kept after chip select rose");

    read_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        !serialDataOe_n |-> !p_reg.csLvl && !commandValid && !dataValid)
        else $error("data line driven outside a read");

endmodule : epd_host_serial_port

// >>> testbench/host_spi_model.sv
/*
 * Host microcontroller model: drives chip select, serial clock, qualifier and
 * write data, and samples the data line in read transfers.
 * Assumes the caller paces it from the bench clock; all changes land on falling clk.
 */
module host_spi_model (
    // Pacing clock
    input wire logic clk,
    // Host pins
    output logic chipSelect_n,
    output logic serialClock,
    output logic dataCommandSel,
    output logic hostData,
    input wire logic sdaLevel
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        chipSelect_n = 1'h1;
        serialClock = 1'h0;
        dataCommandSel = 1'h0;
        hostData = 1'h1;
    end

    task automatic pause(input int n);
        repeat (n) @(negedge clk);
    endtask : pause

    task automatic selectLow();
        chipSelect_n = 1'h0;
        pause(6);
    endtask : selectLow

    // Gap longer than the port's filter so the rise is never missed
    task automatic selectHigh(input int h);
        pause(h);
        chipSelect_n = 1'h1;
        hostData = ~hostData;
        pause(8);
    endtask : selectHigh

    // Qualifier held for the whole frame; clock idles low between frames
    task automatic sendBits(input int n, input logic [8:0] v, input logic dcv, input int h);
        for (int i = n - 1; i >= 0; i--)
        begin
            hostData = v[i];
            dataCommandSel = dcv;
            pause(h);
            serialClock = 1'h1;
            pause(h);
            serialClock = 1'h0;
        end
        hostData = ~hostData;
    endtask : sendBits

    // Slow clock for reads; each bit sampled just before the rising edge
    task automatic readByte(input int h, output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            pause(h);
            b[i] = sdaLevel;
            serialClock = 1'h1;
            pause(h);
            serialClock = 1'h0;
        end
    endtask : readByte

endmodule : host_spi_model

// >>> testbench/tb_top.sv
/*
 * Self-checking bench of the host serial port: write frames in both modes,
 * aborts, reset pin, read return, busy sources and a sensor read.
 * Assumes a pull-up on the sensor data line and a sensor that never answers.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'h0;
    logic rst_n;
    logic resetPin_n;
    logic strap;
    logic readLoad;
    logic [7:0] readData;
    logic waveformActive;
    logic sensorStart;
    logic chipSelect_n;
    logic serialClock;
    logic dataCommandSel;
    logic hostData;
    logic sdaWire;
    logic serialDataOut;
    logic serialDataOe_n;
    logic busy;
    logic commandValid;
    logic dataValid;
    logic [7:0] byteData;
    logic [15:0] sensorReading;
    logic sensorI2cClock;
    logic sensorI2cDataOut;
    logic sensorI2cDataOe_n;
    logic sensorWire;
    logic sclPrev;
    logic [8:0] got[$];
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int sclRises = 0;
    int bothSeen = 0;
    int sdaPulls = 0;

    always #5 clk = ~clk;

    assign sdaWire = serialDataOe_n ? hostData : serialDataOut;
    // Released sensor line floats high through its pull-up
    assign sensorWire = sensorI2cDataOe_n ? 1'h1 : sensorI2cDataOut;

    host_spi_model host_spi_model_inst (
        .clk(clk),
        .chipSelect_n(chipSelect_n),
        .serialClock(serialClock),
        .dataCommandSel(dataCommandSel),
        .hostData(hostData),
        .sdaLevel(sdaWire)
    );

    epd_host_serial_port epd_host_serial_port_inst (
        .clk(clk),
        .rst_n(rst_n),
        .reset_low_input_n(resetPin_n),
        .interfaceWidthStrap(strap),
        .chipSelect_n(chipSelect_n),
        .serialClock(serialClock),
        .dataCommandSel(dataCommandSel),
        .serialDataIn(sdaWire),
        .serialDataOut(serialDataOut),
        .serialDataOe_n(serialDataOe_n),
        .busy(busy),
        .byteData(byteData),
        .commandValid(commandValid),
        .dataValid(dataValid),
        .readLoad(readLoad),
        .readData(readData),
        .waveformActive(waveformActive),
        .sensorStart(sensorStart),
        .sensorReading(sensorReading),
        .sensorI2cClock(sensorI2cClock),
        .sensorI2cDataIn(sensorWire),
        .sensorI2cDataOut(sensorI2cDataOut),
        .sensorI2cDataOe_n(sensorI2cDataOe_n)
    );

    always @(posedge clk)
    begin
        cycles++;
        sclPrev <= sensorI2cClock;
        if (sensorI2cClock === 1'h1 && sclPrev === 1'h0)
            sclRises++;
        if (commandValid === 1'h1 || dataValid === 1'h1)
            got.push_back({dataValid, byteData});
        if (commandValid === 1'h1 && dataValid === 1'h1)
            bothSeen++;
        if (sensorI2cDataOe_n === 1'h0)
            sdaPulls++;
        if (cycles == 80000)
        begin
            n_errors++;
            $display("[ERR] %0t ns: run did not finish in time", $time);
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic popByte(input logic [8:0] exp);
        logic [15:0] seen;
        seen = (got.size() > 0) ? {7'h00, got.pop_front()} : 16'hDEAD;
        check(seen, {7'h00, exp});
    endtask : popByte

    task automatic settle(input string name);
        host_spi_model_inst.pause(12);
        check(16'(got.size()), 16'h0000);
        check(16'(bothSeen), 16'h0000);
        $display("test %s finished", name);
    endtask : settle

    task automatic testFourWire();
        host_spi_model_inst.selectLow();
        host_spi_model_inst.sendBits(8, 9'h0A5, 1'h0, 5);
        host_spi_model_inst.sendBits(8, 9'h03C, 1'h1, 5);
        host_spi_model_inst.selectHigh(5);
        popByte(9'h0A5);
        popByte(9'h13C);
        // Clock edges with chip select high must be ignored
        host_spi_model_inst.sendBits(8, 9'h0FF, 1'h1, 5);
        settle("four_wire");
    endtask : testFourWire

    task automatic testAbort();
        host_spi_model_inst.selectLow();
        host_spi_model_inst.sendBits(3, 9'h005, 1'h1, 5);
        host_spi_model_inst.selectHigh(5);
        host_spi_model_inst.selectLow();
        host_spi_model_inst.sendBits(8, 9'h081, 1'h1, 5);
        host_spi_model_inst.selectHigh(5);
        popByte(9'h181);
        settle("abort");
    endtask : testAbort

    // Half a byte, then the reset pin, then the other half: no byte may form
    task automatic testResetPin();
        host_spi_model_inst.selectLow();
        host_spi_model_inst.sendBits(4, 9'h00C, 1'h0, 5);
        resetPin_n = 1'h0;
        host_spi_model_inst.pause(8);
        check({15'h0000, busy}, 16'h0000);
        resetPin_n = 1'h1;
        host_spi_model_inst.pause(6);
        host_spi_model_inst.sendBits(4, 9'h003, 1'h0, 5);
        host_spi_model_inst.selectHigh(5);
        check(16'(got.size()), 16'h0000);
        host_spi_model_inst.selectLow();
        host_spi_model_inst.sendBits(8, 9'h042, 1'h0, 5);
        host_spi_model_inst.selectHigh(5);
        popByte(9'h042);
        settle("reset_pin");
    endtask : testResetPin

    task automatic testThreeWire();
        strap = 1'h1;
        host_spi_model_inst.pause(8);
        host_spi_model_inst.selectLow();
        host_spi_model_inst.sendBits(9, 9'h0C3, 1'h0, 5);
        host_spi_model_inst.sendBits(9, 9'h15A, 1'h0, 5);
        host_spi_model_inst.selectHigh(5);
        popByte(9'h0C3);
        popByte(9'h15A);
        strap = 1'h0;
        host_spi_model_inst.pause(8);
        settle("three_wire");
    endtask : testThreeWire

    task automatic testRead();
        logic [7:0] b;
        readData = 8'h96;
        readLoad = 1'h1;
        host_spi_model_inst.pause(1);
        readLoad = 1'h0;
        host_spi_model_inst.selectLow();
        check({15'h0000, serialDataOe_n}, 16'h0000);
        host_spi_model_inst.readByte(20, b);
        check({8'h00, b}, 16'h0096);
        host_spi_model_inst.selectHigh(20);
        check({15'h0000, serialDataOe_n}, 16'h0001);
        settle("read");
    endtask : testRead

    task automatic testBusy();
        int n;
        waveformActive = 1'h1;
        host_spi_model_inst.pause(4);
        check({15'h0000, busy}, 16'h0001);
        waveformActive = 1'h0;
        host_spi_model_inst.pause(4);
        check({15'h0000, busy}, 16'h0000);
        sclRises = 0;
        sensorStart = 1'h1;
        host_spi_model_inst.pause(1);
        sensorStart = 1'h0;
        host_spi_model_inst.pause(3);
        check({15'h0000, busy}, 16'h0001);
        n = 0;
        // Host stays quiet until busy drops
        while (busy !== 1'h0 && n < 40000)
        begin
            host_spi_model_inst.pause(1);
            n++;
        end
        check({15'h0000, busy}, 16'h0000);
        check(sensorReading, 16'hFFFF);
        check({15'h0000, sclRises >= 27}, 16'h0001);
        check({15'h0000, sensorI2cClock}, 16'h0001);
        check({15'h0000, sensorI2cDataOe_n}, 16'h0001);
        check({15'h0000, sensorI2cDataOut}, 16'h0000);
        check({15'h0000, sdaPulls > 0}, 16'h0001);
        settle("busy_sensor");
    endtask : testBusy

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        rst_n = 1'h0;
        resetPin_n = 1'h1;
        strap = 1'h0;
        readLoad = 1'h0;
        readData = 8'h00;
        waveformActive = 1'h0;
        sensorStart = 1'h0;
        repeat (12) @(negedge clk);
        rst_n = 1'h1;
        check({15'h0000, busy}, 16'h0000);
        check({15'h0000, serialDataOe_n}, 16'h0001);
        testFourWire();
        testAbort();
        testResetPin();
        testThreeWire();
        testRead();
        testBusy();
        report_and_stop();
    end

endmodule : tb_top
